// ### hw/dpp_pkg.sv
// constants and types for downstream port power control
// What this block does
// [RQ1] enabled port: pin input with pull-up
// [RQ2] enabled port: low pin means overcurrent
// [RQ3] monitor pulls line low on overcurrent
// [RQ4] disabled port: pin driven low output
// [RQ5] split off: pin powers both halves
// [RQ6] split on: pin powers high-speed only
// [RQ7] split on: port 3 superspeed output follows enable
// [RQ8] split off: port 3 superspeed output unused
// [RQ9] fixed physical to logical port remap
// [RQ10] logical ports map onto listed physical PHYs
// [RQ11] synchronise, filter overcurrent; ignore while driving
// [RQ12] overcurrent latched until cleared or disabled
package dpp_pkg;
  localparam int NUM_CTL_PORTS = 3;
  localparam int NUM_SS_PHY    = 6;
  localparam int NUM_HS_PHY    = 7;
  localparam int NUM_LOGICAL   = 5;
  localparam int PHY_IDX_W     = 3;
  // index of each control pin in the per-port vectors
  localparam int IDX_P1 = 0;
  localparam int IDX_P3 = 1;
  localparam int IDX_P4 = 2;
  // logical port number behind each control pin, in vector order
  localparam int CTL_LOG [NUM_CTL_PORTS] = '{1, 3, 4};
  // overcurrent filter: low level must persist this long
  localparam int OC_FILTER_NS  = 1000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int OC_FILTER_CYC = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [PHY_IDX_W-1:0] PHY_NONE = 3'h7;

  typedef struct packed {
    logic [PHY_IDX_W-1:0] hs_phy;
    logic [PHY_IDX_W-1:0] ss_phy_a;
    logic [PHY_IDX_W-1:0] ss_phy_b;
  } dpp_map_s;

  typedef struct packed {
    logic [NUM_CTL_PORTS-1:0] pin_o;
    logic [NUM_CTL_PORTS-1:0] pin_oe;
    logic [NUM_CTL_PORTS-1:0] pull_up;
  } dpp_pin_s;

  // logical 0..4 -> physical; port 4 has no superspeed pair
  localparam dpp_map_s [NUM_LOGICAL-1:0] LOG_MAP = '{
    '{hs_phy: 3'h2, ss_phy_a: PHY_NONE, ss_phy_b: PHY_NONE},
    '{hs_phy: 3'h5, ss_phy_a: 3'h5,     ss_phy_b: PHY_NONE},
    '{hs_phy: 3'h3, ss_phy_a: 3'h3,     ss_phy_b: 3'h4},
    '{hs_phy: 3'h1, ss_phy_a: 3'h1,     ss_phy_b: 3'h2},
    '{hs_phy: 3'h0, ss_phy_a: 3'h0,     ss_phy_b: PHY_NONE}
  };
endpackage

// ### hw/dpp_port_power.sv
// downstream port power enable and overcurrent sense
`timescale 1ns/1ps
module dpp_port_power import dpp_pkg::*; #(
  parameter int NPORT     = NUM_CTL_PORTS,
  parameter int FILT_CYC  = OC_FILTER_CYC
) (
  input  wire logic             ref_clk_i,            // 50 MHz core clock
  input  wire logic             reset_i,              // sync reset, high
  input  wire logic [NPORT-1:0] port_enable_i,        // config and host enable
  input  wire logic             split_mode_i,         // split mode on
  input  wire logic             port3_ss_enable_i,    // port 3 superspeed enable
  input  wire logic [NPORT-1:0] oc_clear_i,           // clear latched overcurrent
  input  wire logic [NPORT-1:0] power_ocs_pin_i,      // pin level: p1,p3,p4
  output logic      [NPORT-1:0] power_ocs_pin_o,      // pin drive value
  output logic      [NPORT-1:0] power_ocs_pin_oe_o,   // pin drive enable
  output logic      [NPORT-1:0] power_ocs_pull_up_o,  // internal pull-up on
  output logic      [NPORT-1:0] hs_power_on_o,        // high-speed half powered
  output logic      [NPORT-1:0] ss_power_on_o,        // superspeed half powered
  output logic                  port3_superspeed_power_enable, // port 3 ss power
  output logic [NUM_HS_PHY-1:0] hs_phy_power_o,       // high-speed PHYs powered
  output logic [NUM_SS_PHY-1:0] ss_phy_power_o,       // superspeed PHYs powered
  output logic      [NPORT-1:0] oc_status_o,          // latched overcurrent
  output logic      [NPORT-1:0] oc_level_o            // filtered live overcurrent
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] FILT_MAX = CW'(FILT_CYC);

  dpp_pin_s pin_next;
  wire logic [NPORT-1:0] ss_on_next;
  wire logic             p3_ss_next;
  wire logic [NPORT-1:0]      ss_half_next;
  wire logic [NUM_HS_PHY-1:0] hs_phy_next;
  wire logic [NUM_SS_PHY-1:0] ss_phy_next;
  logic [NPORT-1:0] sync1_reg;
  logic [NPORT-1:0] sync2_reg;
  logic [NPORT-1:0] oc_flt_reg;

  always_comb begin
    pin_next.pin_o   = '0;              // RQ4
    pin_next.pin_oe  = ~port_enable_i;  // RQ4
    pin_next.pull_up = port_enable_i;   // RQ1
  end

  // split on: pin no longer carries the superspeed half
  assign ss_on_next = split_mode_i ? '0 : port_enable_i; // RQ5 RQ6
  // split off: hold low so an embedded device stays unpowered
  assign p3_ss_next = split_mode_i & port3_ss_enable_i; // RQ7 RQ8
  // split output owns the port 3 superspeed pair
  assign ss_half_next = ss_on_next | (NPORT'(p3_ss_next) << IDX_P3); // RQ7

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      logic [CW-1:0] cnt_reg;
      logic [1:0]    arm_reg;
      wire  logic    sense_low;
      // after release the synchroniser still holds our own low drive
      always_ff @(posedge ref_clk_i) begin
        if (reset_i || !port_enable_i[g]) begin
          arm_reg <= '0;
        end else begin
          arm_reg <= {arm_reg[0], ~power_ocs_pin_oe_o[g]};
        end
      end
      // sense only once the pin is an input and its level has synced
      assign sense_low = ~sync2_reg[g] & arm_reg[1] & port_enable_i[g]; // RQ2 RQ11
      always_ff @(posedge ref_clk_i) begin
        if (reset_i || !sense_low) begin
          cnt_reg       <= '0;
          oc_flt_reg[g] <= 1'b0;
        end else if (cnt_reg == FILT_MAX) begin
          oc_flt_reg[g] <= 1'b1; // RQ11
        end else begin
          cnt_reg <= cnt_reg + CW'(1);
        end
      end
      always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
          oc_status_o[g] <= 1'b0;
        end else if (oc_flt_reg[g] && port_enable_i[g]) begin
          oc_status_o[g] <= 1'b1; // RQ12
        end else if (oc_clear_i[g] || !port_enable_i[g]) begin
          oc_status_o[g] <= 1'b0; // RQ12
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= power_ocs_pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      power_ocs_pin_o               <= '0;
      power_ocs_pin_oe_o            <= '1;
      power_ocs_pull_up_o           <= '0;
      hs_power_on_o                 <= '0;
      ss_power_on_o                 <= '0;
      port3_superspeed_power_enable <= 1'b0;
      oc_level_o                    <= '0;
      hs_phy_power_o                <= '0;
      ss_phy_power_o                <= '0;
    end else begin
      power_ocs_pin_o               <= pin_next.pin_o;
      power_ocs_pin_oe_o            <= pin_next.pin_oe;
      power_ocs_pull_up_o           <= pin_next.pull_up;
      hs_power_on_o                 <= port_enable_i;
      ss_power_on_o                 <= ss_on_next;
      port3_superspeed_power_enable <= p3_ss_next;
      oc_level_o                    <= oc_flt_reg;
      hs_phy_power_o                <= hs_phy_next;
      ss_phy_power_o                <= ss_phy_next;
    end
  end

  // logical port power spread onto the physical PHYs; unmapped PHYs stay off
  genvar p, q;
  for (p = 0; p < NUM_HS_PHY; p++) begin : g_hs_phy
    wire logic [NPORT-1:0] hit;
    for (q = 0; q < NPORT; q++) begin : g_hit
      localparam dpp_map_s MAP_ENT = LOG_MAP[CTL_LOG[q]];
      assign hit[q] = port_enable_i[q] & (MAP_ENT.hs_phy == PHY_IDX_W'(p)); // RQ9 RQ10
    end
    assign hs_phy_next[p] = |hit;
  end

  for (p = 0; p < NUM_SS_PHY; p++) begin : g_ss_phy
    wire logic [NPORT-1:0] hit;
    for (q = 0; q < NPORT; q++) begin : g_hit
      localparam dpp_map_s MAP_ENT = LOG_MAP[CTL_LOG[q]];
      wire logic own;
      assign own    = (MAP_ENT.ss_phy_a == PHY_IDX_W'(p)) | (MAP_ENT.ss_phy_b == PHY_IDX_W'(p));
      assign hit[q] = ss_half_next[q] & own; // RQ9 RQ10
    end
    assign ss_phy_next[p] = |hit;
  end
endmodule

// ### test/dpp_monitor_model.sv
// power switch and current monitor model on the control lines
`timescale 1ns/1ps
module dpp_monitor_model (input wire logic [2:0] drv_i, oe_i, pu_i, fault_i, output logic [2:0] line_o);
  // monitor only ever pulls low; an undriven line rests on the pull-up
  assign line_o = (oe_i & drv_i) | (~oe_i & ~fault_i & pu_i);
endmodule

// ### test/dpp_port_power_sva.sv
// assertions on the port power control pins
`timescale 1ns/1ps
module dpp_port_power_sva #(parameter int NPORT = 3, parameter int FILT_CYC = 3) (
  input wire logic ref_clk_i, reset_i, split_mode_i, port3_ss_enable_i,
  input wire logic port3_superspeed_power_enable,
  input wire logic [NPORT-1:0] port_enable_i, oc_clear_i, power_ocs_pin_i, power_ocs_pin_o,
  input wire logic [NPORT-1:0] power_ocs_pin_oe_o, power_ocs_pull_up_o, hs_power_on_o,
  input wire logic [NPORT-1:0] ss_power_on_o, oc_status_o, oc_level_o);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_oc_rise; $rose(oc_level_o[0]); endsequence
  a_pull_follow: assert property (1 |=> power_ocs_pull_up_o == $past(port_enable_i))
    else $error("pull-up wrong");
  a_drive_low: assert property (1 |=> power_ocs_pin_oe_o == ~$past(port_enable_i)
    && power_ocs_pin_o == '0) else $error("drive wrong");
  a_ss_together: assert property (!split_mode_i |=> ss_power_on_o == $past(port_enable_i))
    else $error("superspeed half wrong");
  a_hs_only: assert property (split_mode_i |=> ss_power_on_o == '0
    && hs_power_on_o == $past(port_enable_i)) else $error("split halves wrong");
  a_ss3_follow: assert property (1 |=> port3_superspeed_power_enable ==
    $past(split_mode_i && port3_ss_enable_i)) else $error("port 3 output wrong");
  a_oc_dropped: assert property (!port_enable_i[0] |=> !oc_status_o[0])
    else $error("status kept");
  a_oc_filter: assert property (s_oc_rise |-> $past(power_ocs_pin_i[0], 4) == 1'b0
    && $past(power_ocs_pin_i[0], FILT_CYC + 4) == 1'b0) else $error("unfiltered level");
  a_oc_latched: assert property (oc_status_o[0] && port_enable_i[0] && !oc_clear_i[0]
    |=> oc_status_o[0]) else $error("status lost");
endmodule
bind dpp_port_power dpp_port_power_sva #(.NPORT(NPORT), .FILT_CYC(FILT_CYC)) u_sva (.*);

// ### test/test_downstream_port_power_ctl.sv
// bench for downstream port power control
`timescale 1ns/1ps
module test_downstream_port_power_ctl import dpp_pkg::*;;
  logic       ref_clk_i = 0, reset_i = 1, split_mode_i = 0, port3_ss_enable_i = 1;
  logic [2:0] port_enable_i = 0, oc_clear_i = 0, flt = 0;
  wire  [2:0] power_ocs_pin_i, power_ocs_pin_o, power_ocs_pin_oe_o, power_ocs_pull_up_o;
  wire  [2:0] hs_power_on_o, ss_power_on_o, oc_status_o, oc_level_o;
  wire        port3_superspeed_power_enable;
  wire  [6:0] hs_phy_power_o;
  wire  [5:0] ss_phy_power_o;
  int         fail_count = 0, total_checks = 0;
  int         cycle_count = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  dpp_port_power #(.FILT_CYC(3)) dut (.*);
  dpp_monitor_model mon (.drv_i(power_ocs_pin_o), .oe_i(power_ocs_pin_oe_o),
    .pu_i(power_ocs_pull_up_o), .fault_i(flt), .line_o(power_ocs_pin_i));
  task chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) fail_count++;
    if (got !== exp) $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  // inputs move on the falling edge, clear of the sampling edge
  task step(input logic s, input logic [2:0] e, f, c, input int n);
    split_mode_i = s; port_enable_i = e; flt = f; oc_clear_i = c;
    repeat (n) @(negedge ref_clk_i);
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task t_power;
    step(0, 7, 0, 0, 2);
    chk({port3_superspeed_power_enable, power_ocs_pull_up_o, power_ocs_pin_oe_o,
      ss_power_on_o}, 10'h1c7);
    chk({hs_phy_power_o, ss_phy_power_o}, 16'h09a6);
    step(1, 5, 0, 0, 2);
    chk({port3_superspeed_power_enable, hs_power_on_o, ss_power_on_o,
      power_ocs_pin_oe_o}, 10'h342);
    chk({hs_phy_power_o, ss_phy_power_o}, 16'h01a0);
    port3_ss_enable_i = 0;
    step(1, 5, 0, 0, 2);
    chk({port3_superspeed_power_enable, ss_phy_power_o, power_ocs_pin_o}, 16'h0000);
  endtask
  // mid-run reset: pins fall back to driven low
  task t_reset;
    reset_i = 1;
    step(0, 7, 0, 0, 2);
    chk({power_ocs_pin_oe_o, power_ocs_pull_up_o, hs_power_on_o,
      port3_superspeed_power_enable, oc_status_o}, 16'h1c00);
    reset_i = 0;
    step(0, 7, 0, 0, 2);
    chk({power_ocs_pull_up_o, power_ocs_pin_oe_o}, 10'h038);
  endtask
  task t_remap;
    chk(LOG_MAP[1], 10'h04a);
    chk({LOG_MAP[2].ss_phy_b, LOG_MAP[3].hs_phy, LOG_MAP[4].hs_phy}, 10'h12a);
  endtask
  // one-cycle glitch, held fault, clear, then fault on a disabled port
  task t_oc;
    step(0, 7, 1, 0, 1);
    step(0, 7, 0, 0, 20);
    chk(oc_status_o, 0);
    step(0, 7, 3, 0, 20);
    chk({oc_status_o, oc_level_o}, 10'h1b);
    step(0, 7, 0, 1, 20);
    chk({oc_status_o, oc_level_o}, 10'h10);
    step(0, 4, 2, 0, 20);
    chk(oc_status_o, 0);
  endtask
  // scenarios need about 100 cycles; the ceiling leaves wide margin
  always @(posedge ref_clk_i) begin
    cycle_count++;
    if (cycle_count == 2000) begin
      fail_count++;
      results;
    end
  end
  initial begin
    step(0, 0, 0, 0, 8);
    reset_i = 0;
    t_power;
    t_reset;
    t_oc;
    t_remap;
    results;
  end
endmodule
